/* common/csa_if.sv */
/*
  Carrier for one carry-save level: three addends in, pseudo sum and carry out.
  Assumes the adding end is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface csa_if #(parameter int W = 72);
  logic [W-1:0] x;
  logic [W-1:0] y;
  logic [W-1:0] z;
  logic [W-1:0] sum;
  logic [W-1:0] carry;
  modport drv (output x, output y, output z, input sum, input carry);
  modport add (input x, input y, input z, output sum, output carry);
endinterface
`default_nettype wire

/* common/fmul_pkg.sv */
/*
  Constants for the multiply exponent and carry-save coefficient path.
  Assumes 60-bit operands: sign in bit 59, exponent 58..48, coefficient 47..0.
*/
package fmul_pkg;
  // ************************************************************
  // Word layout
  // ************************************************************
  localparam int OPER_W = 60;
  localparam int SIGN_BIT = 59;
  localparam int EXP_LSB = 48;
  localparam int EXP_W = 11;
  localparam int COEF_W = 48;
  localparam int HALF_W = 24;
  localparam int PROD_W = 96;
  localparam int HI_W = 72;
  localparam int NORM_BIT = 95;
  // ************************************************************
  // Exponent arithmetic
  // ************************************************************
  localparam int SUM_W = 13;
  localparam int GROUP_W = 3;
  localparam int N_GROUPS = 5;
  localparam int BIAS_BIT = 10;
  localparam logic [SUM_W-1:0] CORR_SP = 13'h0030;
  localparam logic [SUM_W-1:0] ONE13 = 13'h0001;
  localparam logic [EXP_W-1:0] BIAS_MASK = 11'h400;
  localparam logic [EXP_W-1:0] EXP_OVF = 11'h7FF;
  localparam logic [EXP_W-1:0] EXP_IND = 11'h3FF;
  localparam logic [EXP_W-1:0] EXP_UNF = 11'h000;
  // ************************************************************
  // Coefficient reduction
  // ************************************************************
  localparam int ROW_W = 16;
  localparam int LOW_GRP_W = 4;
  localparam int LOW_GROUPS = 6;
  localparam int ROUND_CARRY_BIT = 47;
  localparam int ROUND_POS = ROUND_CARRY_BIT - 1 - HALF_W;
  // ************************************************************
  // Sequencing
  // ************************************************************
  localparam int PIPE_DEPTH = 5;
endpackage

/* rtl/csa_level.sv */
/*
  One three-to-two carry-save level of parameterised width.
  Assumes the driver keeps the total below 2**W so the dropped top carry is zero.
*/
`timescale 1ns/1ps
`default_nettype none
module csa_level (
  csa_if.add port_io
);
  logic [$bits(port_io.x)-1:0] x_dup;
  logic [$bits(port_io.x)-1:0] y_dup;
  logic [$bits(port_io.x)-1:0] z_dup;
  logic [$bits(port_io.x)-1:0] maj;

  // ************************************************************
  // Reduction
  // ************************************************************
  // Separate copies feed the carry so bit N sees bit N-1 inputs
  assign x_dup = port_io.x; // [RULE12] [RULE18]
  assign y_dup = port_io.y;
  assign z_dup = port_io.z;
  assign port_io.sum = port_io.x ^ port_io.y ^ port_io.z;
  assign maj = (x_dup & y_dup) | (x_dup & z_dup) | (y_dup & z_dup);
  assign port_io.carry = {maj[$bits(port_io.x)-2:0], 1'b0}; // [RULE12] [RULE18]
endmodule
`default_nettype wire

/* rtl/float_multiply_exponent_and_csa.sv */
/*
  Five-period floating multiply: exponent adders with bypass, two-pass
  carry-save coefficient reduction and the split final add.
  Assumes issue logic never issues in the period right after an issue.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Sum complemented exponents, add 060 if single
// RULE2: Decrement exponent when coefficient shifted left
// RULE3: Check input and range special cases, flag
// RULE4: Static ones-complement exponent sum, periods two-three
// RULE5: Correction enters only at bits four, five
// RULE6: Resolve in three-bit groups, complemented result
// RULE7: Minus one by incrementing complement, flip bias
// RULE8: Bypass path restores bias without decrement
// RULE9: Busy set after issue, ranks steer data
// RULE10: Second level reduces, registers one period
// RULE11: Pass one alone, pass two merges loop
// RULE12: Duplicate inputs feed neighbour slice carry
// RULE13: Merge loop bits shifted right twenty-four
// RULE14: Low slice holds loop bits, forms groups
// RULE15: Two round copies make carry into 47
// RULE16: Loop bits passed back only in period three
// RULE17: Pass two reduces bits to two each
// RULE18: Third level gets duplicate neighbour copies
// RULE19: Final add: enables/carries, then propagate
// RULE20: Third addend zero double, 060 single
// RULE21: Shift left only when bit 95 zero
// RULE22: One shift signal picks exponent and coefficient
module float_multiply_exponent_and_csa
  import fmul_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic issue_in,
  input wire logic double_in,
  input wire logic round_in,
  input wire logic [OPER_W-1:0] first_operand_in,
  input wire logic [OPER_W-1:0] second_operand_in,
  output logic busy_out,
  output logic result_valid_out,
  output logic [OPER_W-1:0] result_out,
  output logic overflow_out,
  output logic underflow_out,
  output logic indefinite_out
);
  typedef struct packed {
    logic [PIPE_DEPTH-1:0] rank;
    logic [PIPE_DEPTH-1:0] dbl;
    logic [PIPE_DEPTH-1:0] rnd;
    logic [PIPE_DEPTH-1:0] sgn;
    logic [OPER_W-1:0] first_operand_reg;
    logic [OPER_W-1:0] second_operand_reg;
    logic [COEF_W-1:0] a1;
    logic [COEF_W-1:0] b1;
    logic [EXP_W-1:0] ea1;
    logic [EXP_W-1:0] eb1;
    logic [2:0] inflag1;
    logic [HI_W-1:0] l2s;
    logic [HI_W-1:0] l2c;
    logic [HALF_W-1:0] ahi2;
    logic [COEF_W-1:0] b2;
    logic [SUM_W-1:0] ps2;
    logic [SUM_W-1:0] pc2;
    logic [2:0] inflag2;
    logic [HI_W-1:0] sb3;
    logic [HI_W-1:0] cb3;
    logic [HI_W-1:0] sd3;
    logic [HI_W-1:0] cd3;
    logic [HALF_W-1:0] lows3;
    logic [HALF_W-1:0] lowc3;
    logic [SUM_W-1:0] cs3;
    logic [2:0] flag3;
    logic [HI_W-1:0] en4;
    logic [HI_W-1:0] cy4;
    logic [HALF_W-1:0] len4;
    logic [HALF_W-1:0] lgn4;
    logic [LOW_GROUPS-1:0] gg4;
    logic [LOW_GROUPS-1:0] gp4;
    logic [SUM_W-1:0] cs4;
    logic [2:0] flag4;
    logic res_valid;
    logic [OPER_W-1:0] result;
    logic ovf;
    logic unf;
    logic ind;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  csa_if #(.W(HI_W)) l2p1_if ();
  csa_if #(.W(HI_W)) l3p1_if ();
  csa_if #(.W(HI_W)) l2a_if ();
  csa_if #(.W(HI_W)) l2b_if ();
  csa_if #(.W(HI_W)) l2d_if ();
  csa_if #(.W(HI_W)) l3a_if ();
  csa_if #(.W(HI_W)) l3b_if ();

  logic accept;
  logic [HI_W-1:0] loop_s;
  logic [HI_W-1:0] loop_c;
  logic [HI_W-1:0] rnd_v;

  // ************************************************************
  // Ones-complement adder
  // ************************************************************
  // Group lookahead keeps the end-around carry to two short passes
  function automatic logic [SUM_W-1:0] oc_add13(input logic [SUM_W-1:0] a,
                                                input logic [SUM_W-1:0] b);
    logic [SUM_W-1:0] en;
    logic [SUM_W-1:0] gn;
    logic [SUM_W-1:0] cy;
    logic [N_GROUPS-1:0] gg;
    logic [N_GROUPS-1:0] gp;
    logic [N_GROUPS:0] gc;
    logic c;
    en = a ^ b;
    gn = a & b;
    cy = '0;
    gg = '0;
    gp = '1;
    gc = '0;
    for (int k = 0; k < N_GROUPS; k++) begin
      for (int i = k * GROUP_W; i < (k + 1) * GROUP_W && i < SUM_W; i++) begin
        gg[k] = gn[i] | (en[i] & gg[k]); // [RULE6]
        gp[k] = gp[k] & en[i];
      end
    end
    for (int p = 0; p < 2; p++) begin
      gc[0] = (p == 0) ? 1'b0 : gc[N_GROUPS];
      for (int k = 0; k < N_GROUPS; k++) begin
        gc[k+1] = gg[k] | (gp[k] & gc[k]); // [RULE6]
      end
    end
    for (int k = 0; k < N_GROUPS; k++) begin
      c = gc[k];
      for (int i = k * GROUP_W; i < (k + 1) * GROUP_W && i < SUM_W; i++) begin
        cy[i] = c;
        c = gn[i] | (en[i] & c);
      end
    end
    return en ^ cy;
  endfunction

  // ************************************************************
  // Carry-save levels
  // ************************************************************
  assign accept = issue_in & ~st_r.rank[0]; // [RULE9]

  // Pass one, second level: lower multiplier half against all of b1
  assign l2p1_if.x = HI_W'(st_r.a1[HALF_W-1:0]) * HI_W'(st_r.b1[ROW_W-1:0]); // [RULE11]
  assign l2p1_if.y = (HI_W'(st_r.a1[HALF_W-1:0]) * HI_W'(st_r.b1[2*ROW_W-1:ROW_W])) << ROW_W;
  assign l2p1_if.z = (HI_W'(st_r.a1[HALF_W-1:0]) * HI_W'(st_r.b1[COEF_W-1:2*ROW_W]))
                     << (2 * ROW_W);
  csa_level l2p1_u (.port_io(l2p1_if));

  // Pass one, third level
  assign l3p1_if.x = st_r.l2s;
  assign l3p1_if.y = st_r.l2c;
  assign l3p1_if.z = '0;
  csa_level l3p1_u (.port_io(l3p1_if));

  // Loop gate stays shut outside period three
  assign loop_s = st_r.rank[2] ? l3p1_if.sum : '0; // [RULE16]
  assign loop_c = st_r.rank[2] ? l3p1_if.carry : '0; // [RULE16]
  assign rnd_v = st_r.rnd[2] ? (HI_W'(1) << ROUND_POS) : '0;

  // Pass two, second level: upper multiplier half plus looped bits
  assign l2a_if.x = HI_W'(st_r.ahi2) * HI_W'(st_r.b2[ROW_W-1:0]); // [RULE11]
  assign l2a_if.y = (HI_W'(st_r.ahi2) * HI_W'(st_r.b2[2*ROW_W-1:ROW_W])) << ROW_W;
  assign l2a_if.z = (HI_W'(st_r.ahi2) * HI_W'(st_r.b2[COEF_W-1:2*ROW_W])) << (2 * ROW_W);
  csa_level l2a_u (.port_io(l2a_if));

  assign l2b_if.x = l2a_if.sum;
  assign l2b_if.y = l2a_if.carry;
  assign l2b_if.z = loop_s >> HALF_W; // [RULE13]
  csa_level l2b_u (.port_io(l2b_if));

  // Two round copies of weight 46 sum to a carry into bit 47
  assign l2d_if.x = loop_c >> HALF_W; // [RULE13]
  assign l2d_if.y = rnd_v; // [RULE15]
  assign l2d_if.z = rnd_v; // [RULE15]
  csa_level l2d_u (.port_io(l2d_if));

  // Pass two, third level in period four
  assign l3a_if.x = st_r.sb3;
  assign l3a_if.y = st_r.cb3;
  assign l3a_if.z = st_r.sd3;
  csa_level l3a_u (.port_io(l3a_if));

  assign l3b_if.x = l3a_if.sum;
  assign l3b_if.y = l3a_if.carry;
  assign l3b_if.z = st_r.cd3;
  csa_level l3b_u (.port_io(l3b_if));

  // ************************************************************
  // Pipeline
  // ************************************************************
  always_comb begin
    logic [OPER_W-1:0] wa, wb, word;
    logic [SUM_W-1:0] xa, xb, cr, tru, dec, byp, esel;
    logic [LOW_GROUPS:0] lc;
    logic [HALF_W-1:0] lcy;
    logic [HI_W:0] hc;
    logic [PROD_W-1:0] prod, coef;
    logic [COEF_W-1:0] cpart;
    logic [EXP_W-1:0] eout;
    logic shift_sel, c, ind3, ovf3, unf3;
    {wa, wb, word, xa, xb, cr, tru, dec, byp, esel} = '0;
    {lc, lcy, hc, prod, coef, cpart, eout} = '0;
    {shift_sel, c, ind3, ovf3, unf3} = '0;
    st_nxt = st_r;

    // Busy flag and its copies advance one rank per period
    st_nxt.rank = {st_r.rank[PIPE_DEPTH-2:0], accept}; // [RULE9]
    st_nxt.dbl = {st_r.dbl[PIPE_DEPTH-2:0], double_in};
    st_nxt.rnd = {st_r.rnd[PIPE_DEPTH-2:0], round_in & ~double_in};
    st_nxt.sgn = {st_r.sgn[PIPE_DEPTH-2:0], 1'b0};
    if (accept) begin
      st_nxt.first_operand_reg = first_operand_in;
      st_nxt.second_operand_reg = second_operand_in;
    end

    // Period one: true values, input special cases
    wa = st_r.first_operand_reg[SIGN_BIT] ? ~st_r.first_operand_reg : st_r.first_operand_reg;
    wb = st_r.second_operand_reg[SIGN_BIT] ? ~st_r.second_operand_reg
                                           : st_r.second_operand_reg;
    st_nxt.sgn[1] = st_r.first_operand_reg[SIGN_BIT] ^ st_r.second_operand_reg[SIGN_BIT];
    if (st_r.rank[0]) begin
      st_nxt.a1 = wa[COEF_W-1:0];
      st_nxt.b1 = wb[COEF_W-1:0];
      st_nxt.ea1 = wa[SIGN_BIT-1:EXP_LSB];
      st_nxt.eb1 = wb[SIGN_BIT-1:EXP_LSB];
      st_nxt.inflag1[2] = (wa[SIGN_BIT-1:EXP_LSB] == EXP_IND) |
                          (wb[SIGN_BIT-1:EXP_LSB] == EXP_IND); // [RULE3]
      st_nxt.inflag1[1] = (wa[SIGN_BIT-1:EXP_LSB] == EXP_OVF) |
                          (wb[SIGN_BIT-1:EXP_LSB] == EXP_OVF); // [RULE3]
      st_nxt.inflag1[0] = (wa[SIGN_BIT-1:EXP_LSB] == EXP_UNF) |
                          (wb[SIGN_BIT-1:EXP_LSB] == EXP_UNF); // [RULE3]
    end

    // Period two: exponent pseudo sums, pass one second level
    xa = {{(SUM_W-EXP_W){~st_r.ea1[BIAS_BIT]}}, ~st_r.ea1[BIAS_BIT], ~st_r.ea1[BIAS_BIT-1:0]};
    xb = {{(SUM_W-EXP_W){~st_r.eb1[BIAS_BIT]}}, ~st_r.eb1[BIAS_BIT], ~st_r.eb1[BIAS_BIT-1:0]};
    xa = xa ^ SUM_W'(BIAS_MASK) ^ {{(SUM_W-EXP_W){1'b1}}, {EXP_W{1'b0}}}; // [RULE1]
    xb = xb ^ SUM_W'(BIAS_MASK) ^ {{(SUM_W-EXP_W){1'b1}}, {EXP_W{1'b0}}}; // [RULE1]
    cr = st_r.dbl[1] ? '0 : CORR_SP; // [RULE20] [RULE1]
    if (st_r.rank[1]) begin
      // Correction vector is zero outside bits 4 and 5
      st_nxt.ps2 = xa ^ xb ^ cr; // [RULE5] [RULE4]
      c = ((xa[SUM_W-1] & xb[SUM_W-1]) | (cr[SUM_W-1] & (xa[SUM_W-1] ^ xb[SUM_W-1])));
      st_nxt.pc2 = {((xa[SUM_W-2:0] & xb[SUM_W-2:0]) |
                     (cr[SUM_W-2:0] & (xa[SUM_W-2:0] ^ xb[SUM_W-2:0]))), c}; // [RULE5]
      st_nxt.inflag2 = st_r.inflag1;
      st_nxt.l2s = l2p1_if.sum; // [RULE10]
      st_nxt.l2c = l2p1_if.carry; // [RULE10]
      st_nxt.ahi2 = st_r.a1[COEF_W-1:HALF_W];
      st_nxt.b2 = st_r.b1;
    end

    // Period three: resolve exponent, range checks, loop and merge
    if (st_r.rank[2]) begin
      st_nxt.cs3 = ~oc_add13(st_r.ps2, st_r.pc2); // [RULE4] [RULE6]
      tru = oc_add13(st_r.ps2, st_r.pc2);
      ind3 = st_r.inflag2[2] | (st_r.inflag2[1] & st_r.inflag2[0]); // [RULE3]
      ovf3 = ~ind3 & (st_r.inflag2[1] |
                      (~tru[SUM_W-1] & (tru[SUM_W-2:BIAS_BIT] != '0))); // [RULE3]
      unf3 = ~ind3 & ~ovf3 & (st_r.inflag2[0] |
                              (tru[SUM_W-1] & (tru[SUM_W-2:BIAS_BIT] != '1))); // [RULE3]
      st_nxt.flag3 = {ind3, ovf3, unf3};
      st_nxt.sb3 = l2b_if.sum; // [RULE10]
      st_nxt.cb3 = l2b_if.carry;
      st_nxt.sd3 = l2d_if.sum;
      st_nxt.cd3 = l2d_if.carry;
      st_nxt.lows3 = loop_s[HALF_W-1:0]; // [RULE14]
      st_nxt.lowc3 = loop_c[HALF_W-1:0]; // [RULE14]
    end

    // Period four: pass two third level, first half of final add
    if (st_r.rank[3]) begin
      st_nxt.en4 = l3b_if.sum ^ l3b_if.carry; // [RULE17] [RULE19]
      st_nxt.cy4 = l3b_if.sum & l3b_if.carry; // [RULE17] [RULE19]
      st_nxt.len4 = st_r.lows3 ^ st_r.lowc3; // [RULE14]
      st_nxt.lgn4 = st_r.lows3 & st_r.lowc3; // [RULE14]
      for (int k = 0; k < LOW_GROUPS; k++) begin
        c = 1'b0;
        for (int i = k * LOW_GRP_W; i < (k + 1) * LOW_GRP_W; i++) begin
          c = (st_r.lows3[i] & st_r.lowc3[i]) | ((st_r.lows3[i] ^ st_r.lowc3[i]) & c);
        end
        st_nxt.gg4[k] = c; // [RULE14]
        st_nxt.gp4[k] = &(st_r.lows3[k*LOW_GRP_W +: LOW_GRP_W] ^
                          st_r.lowc3[k*LOW_GRP_W +: LOW_GRP_W]); // [RULE14]
      end
      st_nxt.cs4 = st_r.cs3;
      st_nxt.flag4 = st_r.flag3;
    end

    // Period five: carry propagation, normalize, exponent select
    lc[0] = 1'b0;
    for (int k = 0; k < LOW_GROUPS; k++) begin
      lc[k+1] = st_r.gg4[k] | (st_r.gp4[k] & lc[k]); // [RULE19]
      c = lc[k];
      for (int i = k * LOW_GRP_W; i < (k + 1) * LOW_GRP_W; i++) begin
        lcy[i] = c;
        c = st_r.lgn4[i] | (st_r.len4[i] & c);
      end
    end
    hc[0] = lc[LOW_GROUPS];
    for (int i = 0; i < HI_W; i++) begin
      hc[i+1] = st_r.cy4[i] | (st_r.en4[i] & hc[i]); // [RULE19]
    end
    prod = {st_r.en4 ^ hc[HI_W-1:0], st_r.len4 ^ lcy};
    shift_sel = ~prod[NORM_BIT]; // [RULE21] [RULE22]
    coef = shift_sel ? (prod << 1) : prod; // [RULE21]
    cpart = st_r.dbl[4] ? coef[COEF_W-1:0] : coef[PROD_W-1:COEF_W];
    dec = ~oc_add13(st_r.cs4, ONE13); // [RULE7] [RULE2]
    byp = ~st_r.cs4; // [RULE8]
    esel = shift_sel ? dec : byp; // [RULE22] [RULE2]
    eout = esel[EXP_W-1:0] ^ BIAS_MASK; // [RULE7] [RULE8]
    st_nxt.res_valid = st_r.rank[4];
    if (st_r.rank[4]) begin
      unique case (1'b1)
        st_r.flag4[2]: word = {1'b0, EXP_IND, {COEF_W{1'b0}}}; // [RULE3]
        st_r.flag4[1]: word = {1'b0, EXP_OVF, {COEF_W{1'b0}}}; // [RULE3]
        st_r.flag4[0]: word = '0; // [RULE3]
        default: word = {1'b0, eout, cpart};
      endcase
      // Negative product goes out in ones-complement form, except the underflow word, which stays zero
      st_nxt.result = (st_r.sgn[4] & ~st_r.flag4[0]) ? ~word : word;
      st_nxt.ind = st_r.flag4[2];
      st_nxt.ovf = st_r.flag4[1];
      st_nxt.unf = st_r.flag4[0];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign busy_out = st_r.rank[0];
  assign result_valid_out = st_r.res_valid;
  assign result_out = st_r.result;
  assign overflow_out = st_r.ovf;
  assign underflow_out = st_r.unf;
  assign indefinite_out = st_r.ind;
endmodule
`default_nettype wire

/* testbench/float_multiply_exponent_and_csa_assertions.sv */
/*
  Port-level checker for the multiply block, bound to its top.
  Assumes the issue side keeps the quiet period except where refused.
*/
`timescale 1ns/1ps
`default_nettype none
module float_multiply_exponent_and_csa_assertions
  import fmul_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic issue_in,
  input wire logic double_in,
  input wire logic round_in,
  input wire logic [OPER_W-1:0] first_operand_in,
  input wire logic [OPER_W-1:0] second_operand_in,
  input wire logic busy_out,
  input wire logic result_valid_out,
  input wire logic [OPER_W-1:0] result_out,
  input wire logic overflow_out,
  input wire logic underflow_out,
  input wire logic indefinite_out
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic acc;
  logic [OPER_W-1:0] fix_w;
  assign acc = issue_in && !busy_out;
  // Sign folded out so one pattern covers both signs
  assign fix_w = result_out ^ {OPER_W{result_out[SIGN_BIT]}};
  property p_busy_set; acc |=> busy_out; endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy missing");
  property p_busy_only; !acc |=> !busy_out; endproperty
  a_busy_only: assert property (p_busy_only) else $error("busy stray");
  property p_latency; acc |-> ##6 result_valid_out; endproperty
  a_latency: assert property (p_latency) else $error("no result");
  property p_no_stray; result_valid_out |-> $past(acc, 6); endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray result");
  property p_pulse; result_valid_out |=> !result_valid_out; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_word_hold; $changed(result_out) |-> result_valid_out; endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved");
  property p_flag_hold;
    $changed({overflow_out, underflow_out, indefinite_out}) |-> result_valid_out;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved");
  property p_flag_one;
    result_valid_out |-> $onehot0({overflow_out, underflow_out, indefinite_out});
  endproperty
  a_flag_one: assert property (p_flag_one) else $error("flags clash");
  property p_ind_word;
    result_valid_out && indefinite_out |-> fix_w == {1'b0, EXP_IND, {COEF_W{1'b0}}};
  endproperty
  a_ind_word: assert property (p_ind_word) else $error("bad ind word");
  property p_ovf_word;
    result_valid_out && overflow_out |-> fix_w == {1'b0, EXP_OVF, {COEF_W{1'b0}}};
  endproperty
  a_ovf_word: assert property (p_ovf_word) else $error("bad ovf word");
  property p_unf_word; result_valid_out && underflow_out |-> result_out == '0; endproperty
  a_unf_word: assert property (p_unf_word) else $error("bad unf word");
endmodule
bind float_multiply_exponent_and_csa float_multiply_exponent_and_csa_assertions
  float_multiply_exponent_and_csa_assertions_i (.clk_in, .arst_n_in, .issue_in, .double_in,
  .round_in, .first_operand_in, .second_operand_in, .busy_out, .result_valid_out,
  .result_out, .overflow_out, .underflow_out, .indefinite_out);
`default_nettype wire

/* testbench/float_multiply_exponent_and_csa_tb_top.sv */
/*
  Self-checking bench: reference results, pipelined issues, refusal, reset.
  Assumes the issue model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module float_multiply_exponent_and_csa_tb_top
  import fmul_pkg::*;
;
  // ************************************************************
  // Harness
  // ************************************************************
  typedef logic [OPER_W+2:0] res_t;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic issue_in, double_in, round_in, busy_out, result_valid_out;
  logic overflow_out, underflow_out, indefinite_out;
  logic [OPER_W-1:0] first_operand_in, second_operand_in, result_out;
  int error_cnt = 0;
  int samples_checked = 0;
  res_t got_q[$];
  res_t exp_q[$];
  always #10 clk_in = ~clk_in;
  fmul_issue_model fmul_issue_model_i (.clk_in(clk_in), .issue_out(issue_in),
    .double_out(double_in), .round_out(round_in), .first_out(first_operand_in),
    .second_out(second_operand_in));
  float_multiply_exponent_and_csa float_multiply_exponent_and_csa_i (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .issue_in(issue_in), .double_in(double_in),
    .round_in(round_in), .first_operand_in(first_operand_in),
    .second_operand_in(second_operand_in), .busy_out(busy_out),
    .result_valid_out(result_valid_out), .result_out(result_out),
    .overflow_out(overflow_out), .underflow_out(underflow_out),
    .indefinite_out(indefinite_out));
  always @(posedge clk_in) begin
    if (result_valid_out === 1'b1) begin
      got_q.push_back({overflow_out, underflow_out, indefinite_out, result_out});
    end
  end
  // ************************************************************
  // Reference and checks
  // ************************************************************
  function automatic logic [SUM_W-1:0] ocsum(input logic [SUM_W-1:0] p, input logic [SUM_W-1:0] q);
    logic [SUM_W:0] t;
    t = {1'b0, p} + {1'b0, q};
    return t[SUM_W-1:0] + SUM_W'(t[SUM_W]);
  endfunction
  function automatic res_t ref_res(input logic [OPER_W-1:0] a, input logic [OPER_W-1:0] b,
                                   input logic d, input logic r);
    logic [EXP_W-1:0] ea, eb, xa, xb;
    logic [SUM_W-1:0] tru, cs, t13;
    logic [PROD_W-1:0] p;
    logic ind, ovf, unf, sh, sg;
    logic [OPER_W-1:0] w;
    sg = a[SIGN_BIT] ^ b[SIGN_BIT];
    if (a[SIGN_BIT]) a = ~a;
    if (b[SIGN_BIT]) b = ~b;
    ea = a[EXP_LSB+:EXP_W];
    eb = b[EXP_LSB+:EXP_W];
    xa = ~ea ^ BIAS_MASK;
    xb = ~eb ^ BIAS_MASK;
    tru = ocsum(ocsum({{2{xa[BIAS_BIT]}}, xa}, {{2{xb[BIAS_BIT]}}, xb}), d ? 13'h0000 : CORR_SP);
    cs = ~tru;
    ind = ea == EXP_IND || eb == EXP_IND || ((ea == EXP_OVF || eb == EXP_OVF) &&
          (ea == EXP_UNF || eb == EXP_UNF));
    ovf = !ind && (ea == EXP_OVF || eb == EXP_OVF || (!tru[12] && tru[11:10] != 2'h0));
    unf = !ind && !ovf && (ea == EXP_UNF || eb == EXP_UNF || (tru[12] && tru[11:10] != 2'h3));
    p = PROD_W'(a[COEF_W-1:0]) * PROD_W'(b[COEF_W-1:0]);
    if (r && !d) p = p + (96'h1 << ROUND_CARRY_BIT);
    sh = !p[NORM_BIT];
    if (sh) p = p << 1;
    t13 = sh ? ~ocsum(cs, ONE13) : ~cs;
    w = {1'b0, t13[EXP_W-1:0] ^ BIAS_MASK, d ? p[COEF_W-1:0] : p[PROD_W-1:COEF_W]};
    if (ind) w = {1'b0, EXP_IND, {COEF_W{1'b0}}};
    else if (ovf) w = {1'b0, EXP_OVF, {COEF_W{1'b0}}};
    else if (unf) w = '0;
    if (sg && !unf) w = ~w;
    return {ovf, unf, ind, w};
  endfunction
  task automatic cmp_word(input logic [OPER_W-1:0] got, input logic [OPER_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flags(input logic [2:0] got, input logic [2:0] exp);
    cmp_word(OPER_W'(got), OPER_W'(exp));
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic run(input logic [OPER_W-1:0] a, input logic [OPER_W-1:0] b,
                     input logic d, input logic r);
    exp_q.push_back(ref_res(a, b, d, r));
    fmul_issue_model_i.issue_op(a, b, d, r);
  endtask
  // Bounded wait, then a few spare cycles to catch extra results
  task automatic drain(input string name);
    int n;
    res_t g, e;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    repeat (3) @(posedge clk_in);
    cmp_word(OPER_W'(got_q.size()), OPER_W'(exp_q.size()));
    if (got_q.size() < exp_q.size()) final_report();
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      g = got_q.pop_front();
      e = exp_q.pop_front();
      cmp_word(g[OPER_W-1:0], e[OPER_W-1:0]);
      cmp_flags(g[OPER_W+2:OPER_W], e[OPER_W+2:OPER_W]);
    end
    got_q.delete();
    exp_q.delete();
    $display("test %s done", name);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      run(60'h401800000000001, 60'h402C00000000000, m[0],
          m[1]);
      run(60'h3F0400000000000, 60'h405400000000001, m[0], m[1]);
      run(60'h400FFFFFFFFFFFF, 60'h400FFFFFFFFFFFF, m[0], m[1]);
      run(60'h400800000000000, 60'h400800000000001, m[0], m[1]);
      drain("modes");
    end
  endtask
  task automatic t_special;
    logic [EXP_W-1:0] ex_a [6] = '{EXP_IND, EXP_OVF, EXP_UNF, EXP_OVF, 11'h7F0, 11'h010};
    logic [EXP_W-1:0] ex_b [6] = '{11'h400, 11'h400, 11'h400, EXP_UNF, 11'h7F0, 11'h010};
    logic [OPER_W-1:0] a;
    for (int i = 0; i < 6; i++) begin
      a = {1'b0, ex_a[i], 48'h900000000000};
      run(i[0] ? ~a : a, {1'b0, ex_b[i], 48'hA00000000000}, 1'b0, 1'b0);
    end
    drain("special");
  endtask
  task automatic t_refused;
    logic [OPER_W-1:0] a = 60'h401800000000000;
    exp_q.push_back(ref_res(a, a, 1'b0, 1'b0));
    fmul_issue_model_i.issue_b2b(a, 60'h500F00000000000);
    drain("refused");
  endtask
  task automatic t_reset;
    run(60'h401800000000000, 60'h402800000000000, 1'b0, 1'b0);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    cmp_flags({busy_out, result_valid_out, indefinite_out}, 3'h0);
    cmp_word(result_out, 60'h0);
    arst_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    cmp_word(OPER_W'(got_q.size()), 60'h0);
    exp_q.delete();
    got_q.delete();
    $display("test reset done");
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_modes();
    t_special();
    t_refused();
    t_reset();
    t_modes();
    final_report();
  end
endmodule
`default_nettype wire

/* testbench/fmul_issue_model.sv */
/*
  Issue side model: presents multiplies with operands and modes.
  Assumes the caller waits for each task to return before the next.
*/
`timescale 1ns/1ps
`default_nettype none
module fmul_issue_model
  import fmul_pkg::*;
(
  input wire logic clk_in,
  output logic issue_out,
  output logic double_out,
  output logic round_out,
  output logic [OPER_W-1:0] first_out,
  output logic [OPER_W-1:0] second_out
);
  // ************************************************************
  // Issue tasks
  // ************************************************************
  initial {issue_out, double_out, round_out, first_out, second_out} = '0;
  task automatic issue_op(input logic [OPER_W-1:0] a, input logic [OPER_W-1:0] b,
                          input logic d, input logic r);
    @(posedge clk_in);
    {issue_out, double_out, round_out, first_out, second_out} <= {1'b1, d, r, a, b};
    @(posedge clk_in);
    // Quiet period after issue; garbled lines, not stale ones
    {issue_out, double_out, round_out, first_out, second_out} <= {1'b0, ~d, ~r, ~a, ~b};
  endtask
  // Breaks the quiet period on purpose; second request must drop
  task automatic issue_b2b(input logic [OPER_W-1:0] a, input logic [OPER_W-1:0] b);
    @(posedge clk_in);
    {issue_out, double_out, round_out, first_out, second_out} <= {3'h4, a, a};
    @(posedge clk_in);
    {first_out, second_out} <= {b, b};
    @(posedge clk_in);
    issue_out <= 1'b0;
  endtask
endmodule
`default_nettype wire
